// *** logic/bpc_port.sv ***
// Buffered port: partial input and output through a shift register,
// timestamped by a port counter that runs on the attached clock block.
// Assumes the core issues one command at a time and drains responses.
// Transfers wait for a running clock; start it before the first one.
`timescale 1ns/1ps
module bpc_port
(
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    input  wire logic                         cmd_valid,
    output logic                              cmd_ready,
    input  wire logic [2:0]                   cmd_op,
    input  wire logic [bpc_pkg::WID_W-1:0]    cmd_width,
    input  wire logic [bpc_pkg::XFER_W-1:0]   cmd_value,
    input  wire logic [bpc_pkg::DIV_W-1:0]    div_half,
    output logic                              rsp_valid,
    input  wire logic                         rsp_ready,
    output logic [bpc_pkg::XFER_W-1:0]        rsp_data,
    output logic [bpc_pkg::CNT_W-1:0]         rsp_time,
    output logic                              exception,
    output logic                              port_clk,
    output logic                              clk_running,
    input  wire logic [bpc_pkg::PORT_W-1:0]   pin_in,
    output logic [bpc_pkg::PORT_W-1:0]        pin_out,
    output logic [bpc_pkg::PORT_W-1:0]        pin_oe
);
    localparam int RSP_W = bpc_pkg::XFER_W + bpc_pkg::CNT_W;

    bpc_pkg::bpc_pt_state_t          state_q;
    logic [bpc_pkg::XFER_W-1:0]      shreg_q;
    logic [bpc_pkg::WID_W-1:0]       left_q;
    logic [bpc_pkg::WID_W-1:0]       width_q;
    logic [bpc_pkg::CNT_W-1:0]       cnt_q;
    logic [bpc_pkg::CNT_W-1:0]       stamp_q;
    logic [bpc_pkg::XFER_W-1:0]      res_q;
    logic [bpc_pkg::PORT_W-1:0]      pin_out_q;
    logic                            oe_q;
    logic                            exc_q;
    logic                            stop_pend_q;
    logic [bpc_pkg::PORT_W-1:0]      pin_s1_q;
    logic [bpc_pkg::PORT_W-1:0]      pin_s2_q;
    bpc_pkg::bpc_pt_state_t          state_d;
    logic [bpc_pkg::XFER_W-1:0]      shreg_d;
    logic [bpc_pkg::WID_W-1:0]       left_d;
    logic [bpc_pkg::WID_W-1:0]       width_d;
    logic                            exc_d;

    wire                             rise;
    wire                             fall;
    wire                             cnt_clear;
    wire                             stop_done;
    wire                             is_in;
    wire                             is_out;
    wire                             is_start;
    wire                             is_stop;
    wire                             width_ok;
    wire                             take;
    wire                             buf_ready;
    wire                             last_in;
    wire                             last_out;
    wire [bpc_pkg::XFER_W-1:0]       val_mask;
    wire [bpc_pkg::XFER_W-1:0]       in_shift;
    wire [RSP_W-1:0]                 buf_out;
    wire                             width_nz;
    wire                             width_lt;
    wire                             width_mul;
    wire                             start_go;
    wire                             stop_go;
    wire                             rsp_push;
    wire [RSP_W-1:0]                 rsp_word;
    wire                             capture;
    wire                             drive;
    wire                             done_in;
    wire                             done_out;
    wire [bpc_pkg::XFER_W-1:0]       in_align;

    // Command decode
    assign is_in    = (cmd_op == bpc_pkg::BPC_CMD_IN);
    assign is_out   = (cmd_op == bpc_pkg::BPC_CMD_OUT);
    assign is_start = (cmd_op == bpc_pkg::BPC_CMD_START);
    assign is_stop  = (cmd_op == bpc_pkg::BPC_CMD_STOP);
    assign take      = cmd_valid && cmd_ready;
    assign start_go  = take && is_start;
    assign stop_go   = take && is_stop;
    assign width_nz  = (cmd_width != '0);
    assign width_lt  = (cmd_width < 6'(bpc_pkg::XFER_W));
    assign width_mul = (cmd_width[1:0] == 2'h0);
    assign width_ok  = width_nz && width_lt && width_mul;
    assign cmd_ready = (state_q == bpc_pkg::BPC_PT_IDLE) && !stop_pend_q;
    assign val_mask  = (32'h00000001 << cmd_width) - 32'h00000001;
    assign in_shift  = {pin_s2_q, shreg_q[bpc_pkg::XFER_W-1:bpc_pkg::PORT_W]};
    assign last_in   = (left_q == 6'(bpc_pkg::PORT_W));
    assign last_out  = (left_q == 6'(bpc_pkg::PORT_W));
    assign exception = exc_q;
    assign pin_out   = pin_out_q;
    assign pin_oe    = {bpc_pkg::PORT_W{oe_q}};

    // sample on rise, drive on fall
    assign capture   = (state_q == bpc_pkg::BPC_PT_IN) && rise;
    assign drive     = (state_q == bpc_pkg::BPC_PT_OUT) && fall;
    assign done_in   = capture && last_in;
    assign done_out  = drive && last_out;
    assign in_align  = in_shift >> (6'(bpc_pkg::XFER_W) - width_q);

    // Response word into the buffer
    assign rsp_push  = (state_q == bpc_pkg::BPC_PT_RESP);
    assign rsp_word  = {res_q, stamp_q};

    bpc_clock_block u_ck
    (
        .clk       (clk),
        .rst_n     (rst_n),
        .div_half  (div_half),
        .start     (start_go),
        .stop      (stop_go),
        .port_clk  (port_clk),
        .rise      (rise),
        .fall      (fall),
        .cnt_clear (cnt_clear),
        .stop_done (stop_done),
        .running   (clk_running)
    );

    bpc_skid #(.W(RSP_W)) u_buf
    (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (rsp_push),
        .in_ready  (buf_ready),
        .in_data   (rsp_word),
        .out_valid (rsp_valid),
        .out_ready (rsp_ready),
        .out_data  (buf_out)
    );

    assign rsp_data = buf_out[RSP_W-1:bpc_pkg::CNT_W];
    assign rsp_time = buf_out[bpc_pkg::CNT_W-1:0];

    // Pin synchroniser
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end
        else
        begin
            pin_s1_q <= pin_in;
            pin_s2_q <= pin_s1_q;
        end
    end

    // Port counter
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_q <= bpc_pkg::CNT_RESET;
        else if (cnt_clear)
            cnt_q <= bpc_pkg::CNT_RESET;
        else if (rise)
            cnt_q <= cnt_q + 16'h0001;
    end

    // Stop stall
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            stop_pend_q <= 1'b0;
        else if (stop_go)
            stop_pend_q <= 1'b1;
        else if (stop_done || !clk_running)
            stop_pend_q <= 1'b0;
    end

    // Transfer sequencer
    always_comb
    begin
        state_d = state_q;
        shreg_d = shreg_q;
        left_d  = left_q;
        width_d = width_q;
        exc_d   = 1'b0;
        case (state_q)
            bpc_pkg::BPC_PT_IDLE:
            begin
                if (take && (is_in || is_out))
                begin
                    if (!width_ok)
                        exc_d = 1'b1;
                    else if (is_in)
                    begin
                        left_d  = cmd_width;
                        width_d = cmd_width;
                        shreg_d = '0;
                        state_d = bpc_pkg::BPC_PT_IN;
                    end
                    else
                    begin
                        left_d  = cmd_width;
                        shreg_d = cmd_value & val_mask;
                        state_d = bpc_pkg::BPC_PT_OUT;
                    end
                end
            end
            bpc_pkg::BPC_PT_IN:
            begin
                if (capture)
                begin
                    shreg_d = in_shift;
                    left_d  = left_q - 6'(bpc_pkg::PORT_W);
                    if (last_in)
                        state_d = bpc_pkg::BPC_PT_RESP;
                end
            end
            bpc_pkg::BPC_PT_OUT:
            begin
                if (drive)
                begin
                    shreg_d = shreg_q >> bpc_pkg::PORT_W;
                    left_d  = left_q - 6'(bpc_pkg::PORT_W);
                    if (last_out)
                        state_d = bpc_pkg::BPC_PT_RESP;
                end
            end
            bpc_pkg::BPC_PT_RESP:
            begin
                if (buf_ready)
                    state_d = bpc_pkg::BPC_PT_IDLE;
            end
            default:
                state_d = bpc_pkg::BPC_PT_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= bpc_pkg::BPC_PT_IDLE;
            shreg_q <= '0;
            left_q  <= '0;
            width_q <= '0;
            exc_q   <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            shreg_q <= shreg_d;
            left_q  <= left_d;
            width_q <= width_d;
            exc_q   <= exc_d;
        end
    end

    // Pin drivers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_out_q <= '0;
            oe_q      <= 1'b0;
        end
        else if (drive)
        begin
            pin_out_q <= shreg_q[bpc_pkg::PORT_W-1:0];
            oe_q      <= 1'b1;
        end
    end

    // Result and timestamp capture
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stamp_q <= '0;
            res_q   <= '0;
        end
        else if (done_in)
        begin
            stamp_q <= cnt_q;
            res_q   <= in_align;
        end
        else if (done_out)
        begin
            stamp_q <= cnt_q;
            res_q   <= '0;
        end
    end
endmodule

// *** logic/bpc_pkg.sv ***
// Constants and types for the buffered port with its clock block.
// Assumes one 40 MHz clock; the core issues commands on a valid and ready handshake port.
// Summary of operation
// - Partial width must be nonzero, below transfer width, multiple of port width
// - Partial input result undefined if shift register already holds enough bits
// - Timestamped partial input returns captured bits and a timestamp
// - Partial output drives only the n low bits of the value
// - Timestamped partial output returns timestamp of the output transfer
// - Clock block produces no edges until started
// - Starting the clock block clears attached port counters to zero
// - Stop waits until clock output is low, then stops; with div_half of 0 or 1 the clock block never stops
// - Stopped clock block generates no edges
package bpc_pkg;
    localparam int PORT_W      = 4;
    localparam int XFER_W      = 32;
    localparam int CNT_W       = 16;
    localparam int WID_W       = 6;
    localparam int DIV_W       = 8;
    localparam int SHCNT_W     = 6;
    localparam logic [DIV_W-1:0] DIV_RESET = 8'h01;
    localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;

    typedef enum logic [2:0] {
        BPC_CMD_IN  = 3'h1,
        BPC_CMD_OUT = 3'h2,
        BPC_CMD_START = 3'h3,
        BPC_CMD_STOP  = 3'h4
    } bpc_cmd_t;

    typedef enum logic [2:0] {
        BPC_CK_STOPPED  = 3'b001,
        BPC_CK_RUNNING  = 3'b010,
        BPC_CK_STOPWAIT = 3'b100
    } bpc_ck_state_t;

    typedef enum logic [3:0] {
        BPC_PT_IDLE  = 4'b0001,
        BPC_PT_IN    = 4'b0010,
        BPC_PT_OUT   = 4'b0100,
        BPC_PT_RESP  = 4'b1000
    } bpc_pt_state_t;
endpackage

// *** logic/bpc_clock_block.sv ***
// Clock block: divides clk into a port clock with start and stop control.
// Assumes the divider value is held stable while the clock runs.
`timescale 1ns/1ps
module bpc_clock_block
(
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic [bpc_pkg::DIV_W-1:0]  div_half,
    input  wire logic                       start,
    input  wire logic                       stop,
    output logic                            port_clk,
    output logic                            rise,
    output logic                            fall,
    output logic                            cnt_clear,
    output logic                            stop_done,
    output logic                            running
);
    bpc_pkg::bpc_ck_state_t      state_q;
    bpc_pkg::bpc_ck_state_t      state_d;
    logic [bpc_pkg::DIV_W-1:0]   div_q;
    logic                        port_clk_q;
    wire                         tick;
    wire                         gen;

    assign gen  = (state_q != bpc_pkg::BPC_CK_STOPPED);
    assign tick = gen && (div_q == 8'h01 || div_q == 8'h00);
    assign rise = tick && !port_clk_q;
    assign fall = tick && port_clk_q;
    assign port_clk  = port_clk_q;
    assign running   = gen;
    assign cnt_clear = start;
    assign stop_done = (state_q == bpc_pkg::BPC_CK_STOPWAIT) && !port_clk_q && !rise;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            bpc_pkg::BPC_CK_STOPPED:
            begin
                if (start)
                    state_d = bpc_pkg::BPC_CK_RUNNING;
            end
            bpc_pkg::BPC_CK_RUNNING:
            begin
                if (stop)
                    state_d = bpc_pkg::BPC_CK_STOPWAIT;
            end
            bpc_pkg::BPC_CK_STOPWAIT:
            begin
                if (stop_done || (!port_clk_q && !rise))
                    state_d = bpc_pkg::BPC_CK_STOPPED;
            end
            default:
                state_d = bpc_pkg::BPC_CK_STOPPED;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q    <= bpc_pkg::BPC_CK_STOPPED;
            div_q      <= bpc_pkg::DIV_RESET;
            port_clk_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            if (!gen || start)
                div_q <= div_half;
            else if (tick)
                div_q <= div_half;
            else
                div_q <= div_q - 8'h01;
            if (start)
                port_clk_q <= 1'b0;
            else if (tick)
                port_clk_q <= !port_clk_q;
        end
    end
endmodule

// *** logic/bpc_skid.sv ***
// Two-entry buffer with valid and ready on both sides.
// Assumes source and sink on the same clock.
`timescale 1ns/1ps
module bpc_skid
#(
    parameter int W = 8
)
(
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    logic [W-1:0] mem_q [2];
    logic         wp_q;
    logic         rp_q;
    logic [1:0]   cnt_q;
    wire          push;
    wire          pop;

    assign in_ready  = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data  = mem_q[rp_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wp_q  <= 1'b0;
            rp_q  <= 1'b0;
            cnt_q <= 2'h0;
            mem_q[0] <= '0;
            mem_q[1] <= '0;
        end
        else
        begin
            if (push)
            begin
                mem_q[wp_q] <= in_data;
                wp_q        <= !wp_q;
            end
            if (pop)
                rp_q <= !rp_q;
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// *** tb/bpc_port_assertions.sv ***
// Checker for the buffered port, watching its ports only.
// Assumes the port's single clock and its active-low reset.
`timescale 1ns/1ps
module bpc_port_chk
(
    input wire logic                       clk,
    input wire logic                       rst_n,
    input wire logic                       cmd_valid,
    input wire logic                       cmd_ready,
    input wire logic [2:0]                 cmd_op,
    input wire logic [bpc_pkg::WID_W-1:0]  cmd_width,
    input wire logic                       rsp_valid,
    input wire logic                       rsp_ready,
    input wire logic [bpc_pkg::XFER_W-1:0] rsp_data,
    input wire logic [bpc_pkg::CNT_W-1:0]  rsp_time,
    input wire logic                       exception,
    input wire logic                       port_clk,
    input wire logic                       clk_running
);
    wire tk = cmd_valid && cmd_ready;
    wire io = tk && (cmd_op == 3'h1 || cmd_op == 3'h2);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_exc_zero_w: assert property (io && cmd_width == 0 |=> exception)
        else $error("no exception for zero width");
    a_exc_wide_w: assert property (io && cmd_width >= 32 |=> exception)
        else $error("no exception for wide width");
    a_exc_odd_w: assert property (io && cmd_width[1:0] != 2'h0 |=> exception)
        else $error("no exception for odd width");
    a_no_exc_ok: assert property (
        io && cmd_width != 0 && cmd_width < 32 && cmd_width[1:0] == 2'h0 |=> !exception)
        else $error("exception for legal width");
    a_start_edges: assert property (
        tk && cmd_op == 3'h3 |=> clk_running ##[0:520] $rose(port_clk))
        else $error("clock did not start");
    a_stop_still: assert property (
        !clk_running && !$past(clk_running) |-> $stable(port_clk))
        else $error("edge while stopped");
    a_stop_low: assert property ($fell(clk_running) |-> !port_clk)
        else $error("stopped while clock high");
    a_stop_ends: assert property (tk && cmd_op == 3'h4 |-> ##[0:520] !clk_running)
        else $error("stop never completed");
    a_rsp_hold: assert property (
        rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data) && $stable(rsp_time))
        else $error("response changed while stalled");
endmodule
bind bpc_port bpc_port_chk i_bpc_port_chk (.*);

// *** tb/bpc_pins.sv ***
// Far-side logic on the pins: counts a nibble per port clock fall, logs pins.
// Assumes the port clock toggles no faster than every few clk cycles.
`timescale 1ns/1ps
module bpc_pins
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       port_clk,
    input  wire logic [3:0] pin_out,
    output logic      [3:0] pin_in
);
    logic       pc_q;
    logic       pc2_q;
    logic [3:0] seen[$];
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pc_q <= 1'b0;
            pc2_q <= 1'b0;
            pin_in <= 4'h0;
        end
        else
        begin
            pc_q <= port_clk;
            pc2_q <= pc_q;
            if (pc_q && !port_clk)
                pin_in <= pin_in + 4'h1;
            if (pc2_q && !pc_q)
                seen.push_back(pin_out);
        end
    end
endmodule

// *** tb/tb_bpc_port.sv ***
// Self-checking bench for the buffered port and its clock block.
// Assumes the pin model counts nibbles and logs pins at port clock falls.
`timescale 1ns/1ps
module tb_bpc_port;
    logic        clk = 1'b0;
    logic        rst_n;
    logic        cmd_valid;
    logic        cmd_ready;
    logic [2:0]  cmd_op;
    logic [5:0]  cmd_width;
    logic [31:0] cmd_value;
    logic [7:0]  div_half;
    logic        rsp_valid;
    logic        rsp_ready;
    logic [31:0] rsp_data;
    logic [15:0] rsp_time;
    logic        exception;
    logic        port_clk;
    logic        clk_running;
    logic [3:0]  pin_in;
    logic [3:0]  pin_out;
    logic [3:0]  pin_oe;
    logic [31:0] rs = 32'h10;
    logic [5:0]  bad_w[6] = '{6'h00, 6'h20, 6'h24, 6'h06, 6'h01, 6'h3F};
    int          bad_count = 0;
    int          checked = 0;
    int          eq[$];
    int          e;
    int          last_t;
    int          first_t;
    logic        hold;
    always #12.5 clk = ~clk;
    bpc_port i_bpc_port (.clk, .rst_n, .cmd_valid, .cmd_ready, .cmd_op, .cmd_width,
        .cmd_value, .div_half, .rsp_valid, .rsp_ready, .rsp_data, .rsp_time, .exception,
        .port_clk, .clk_running, .pin_in, .pin_out, .pin_oe);
    bpc_pins i_bpc_pins (.clk, .rst_n, .port_clk, .pin_out, .pin_in);
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    function automatic logic [31:0] exp_in(logic [3:0] f, int n);
        logic [31:0] r;
        r = 32'h0;
        for (int i = 0; i < n / 4; i++)
            r[4*i +: 4] = 4'(f + i);
        return r;
    endfunction
    task chk(string nm, logic [31:0] x, logic [31:0] got);
        checked++;
        if (got !== x)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, got);
        end
    endtask
    task test_done();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task issue(logic [2:0] op, logic [5:0] w, logic [31:0] v);
        int i;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_width <= w;
        cmd_value <= v;
        if (op != 3'h3 && op != 3'h4 && w != 0 && w < 32 && w[1:0] == 2'h0)
            eq.push_back(op == 3'h2 ? w + 64 : w);
        i = 0;
        do @(posedge clk); while (cmd_ready !== 1'b1 && ++i < 3000);
        cmd_valid <= 1'b0;
        if (i >= 3000)
            bad_count++;
    endtask
    task drain();
        for (int i = 0; i < 3000 && eq.size() != 0; i++)
            @(posedge clk);
        if (eq.size() != 0)
            bad_count++;
    endtask
    task out_xfer(int n, logic [31:0] v);
        int ok;
        int hit;
        issue(3'h2, 6'(n), v);
        i_bpc_pins.seen.delete();
        drain();
        repeat (30) @(posedge clk);
        ok = 0;
        for (int k = 0; k < 2; k++)
        begin
            hit = 1;
            for (int i = 0; i <= n / 4; i++)
                if (i_bpc_pins.seen.size() <= k + i ||
                    i_bpc_pins.seen[k+i] !== v[4*(i < n / 4 ? i : n / 4 - 1) +: 4])
                    hit = 0;
            ok = ok | hit;
        end
        chk("pin_out order", 1, ok);
        chk("pin_oe", 4'hF, pin_oe);
    endtask
    task start();
        drain();
        issue(3'h3, 6'h00, 32'h0);
        last_t = -1;
    endtask
    always @(posedge clk)
    begin
        rsp_ready <= !hold && (rnd() % 2 == 1);
        if (rsp_valid === 1'b1 && rsp_ready === 1'b1)
        begin
            e = eq.size() == 0 ? -1 : eq.pop_front();
            chk("rsp expected", 1, e >= 0);
            if (e >= 0 && e < 64)
                chk("rsp_data in", exp_in(rsp_data[3:0], e), rsp_data);
            if (e >= 64)
                chk("rsp_data out", 32'h0, rsp_data);
            chk("rsp_time", 1, int'(rsp_time) > last_t && int'(rsp_time) - last_t <= 20);
            if (last_t < 0)
                first_t = int'(rsp_time);
            last_t = int'(rsp_time);
        end
    end
    initial
    begin
        repeat (60000) @(posedge clk);
        bad_count++;
        test_done();
    end
    initial
    begin
        rst_n = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = 3'h0;
        cmd_width = 6'h00;
        cmd_value = 32'h0;
        div_half = 8'h06;
        hold = 1'b0;
        rsp_ready = 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (20) @(posedge clk) #1 chk("port_clk idle", 0, port_clk);
        start();
        foreach (bad_w[j])
            for (int o = 1; o <= 2; o++)
            begin
                issue(3'(o), bad_w[j], rnd());
                #1 chk("exception", 1, exception);
                @(posedge clk) #1 chk("exception pulse", 0, exception);
            end
        issue(3'h1, 6'h1C, 32'h0);
        issue(3'h1, 6'h04, 32'h0);
        out_xfer(4, 32'hFFFFFFF5);
        out_xfer(28, rnd());
        for (int t = 0; t < 30; t++)
            if (rnd() % 2 == 0)
                issue(3'h1, 6'(4 * (1 + rnd() % 7)), rnd());
            else
                out_xfer(4 * (1 + rnd() % 7), rnd());
        drain();
        hold = 1'b1;
        issue(3'h1, 6'h08, 32'h0);
        issue(3'h1, 6'h0C, 32'h0);
        repeat (150) @(posedge clk);
        #1 chk("rsp held", 1, rsp_valid);
        hold = 1'b0;
        drain();
        issue(3'h4, 6'h00, 32'h0);
        for (int i = 0; i < 100 && clk_running === 1'b1; i++)
            @(posedge clk);
        #1 chk("stop low", 0, port_clk);
        chk("stop done", 0, clk_running);
        repeat (40) @(posedge clk) #1 chk("port_clk stopped", 0, port_clk);
        start();
        issue(3'h1, 6'h08, 32'h0);
        drain();
        chk("rsp_time after start", 1, first_t);
        test_done();
    end
endmodule
